// ### verilog/spr_controller.sv
// spr_controller: always-on power cut/restore controller with seconds counter,
// trimmable predivider, battery monitor, retained words and one ORed interrupt.
// assumes crystal_input_i, wake_n_i and battery_low_i are synchronous to clk_i;
// the reference input must run at no more than clk_i/2.
`timescale 1ns/10ps
`default_nettype none

module spr_controller #(
    parameter int ADDR_W = 12,
    parameter int WORDS  = 64
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              crystal_input_i,
    input  wire logic              wake_n_i,
    input  wire logic              battery_low_i,
    output logic                   regulator_off_n_o,
    output logic                   irq_o
);

    // merge write data into an old value by byte lanes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    localparam logic [6:0] DATA_BASE = 7'(spr_pkg::OFF_DATA_LO >> 2);
    localparam logic [6:0] DATA_TOP  = 7'(spr_pkg::OFF_DATA_HI >> 2);

    logic [31:0]                count_reg;
    logic [31:0]                match_a_reg;
    logic [31:0]                match_b_reg;
    logic [31:0]                load_reg;
    // one bit above nominal so trim can slow the count as well as speed it
    logic [15:0]                trim_reg;
    spr_pkg::spr_ctl_type       ctl_reg;
    spr_pkg::spr_event_type     raw_reg;
    spr_pkg::spr_event_type     mask_reg;
    logic [31:0]                retained_words [WORDS];
    logic                       off_reg;
    logic                       ack_reg;
    logic [31:0]                rdata_reg;
    logic                       irq_reg;
    logic                       xtal_prev_reg;
    logic                       wake_prev_n_reg;
    logic [6:0]                 xdiv_reg;
    logic [15:0]                prediv_reg;
    logic [5:0]                 sec64_reg;
    logic                       eq_a_reg;
    logic                       eq_b_reg;

    // bus decode; ack masks req so a strobe still held in the ack cycle is not taken twice
    wire        req       = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire        wr        = req & wb_we_i;
    wire [11:0] adr       = 12'(wb_adr_i);
    wire [6:0]  word_idx  = adr[8:2];
    wire        data_hit  = (adr[11:9] == 3'h0) && (word_idx >= DATA_BASE) && (word_idx <= DATA_TOP);
    wire [5:0]  data_ptr  = 6'(word_idx - DATA_BASE);
    wire [31:0] wmerge_ctl = lane_merge({24'h000000, ctl_reg}, wb_dat_i, wb_sel_i);

    wire wr_match_a = wr && adr == spr_pkg::OFF_MATCH_A;
    wire wr_match_b = wr && adr == spr_pkg::OFF_MATCH_B;
    wire wr_load    = wr && adr == spr_pkg::OFF_LOAD;
    wire wr_ctl     = wr && adr == spr_pkg::OFF_CTL;
    wire wr_mask    = wr && adr == spr_pkg::OFF_MASK;
    wire wr_clear   = wr && adr == spr_pkg::OFF_CLEAR && wb_sel_i[0];
    wire wr_trim    = wr && adr == spr_pkg::OFF_TRIM;
    wire wr_data    = wr && data_hit;

    // reference tick generation
    wire xtal_rise = crystal_input_i & ~xtal_prev_reg;
    wire xdiv_wrap = xtal_rise && xdiv_reg == 7'(spr_pkg::XTAL_DIV - 1);
    wire ref_tick  = ctl_reg.ref_clock_enable
                   & (ctl_reg.ref_source_select ? xtal_rise : xdiv_wrap);
    wire sec_tick  = ref_tick && prediv_reg == 16'h0000;
    wire [15:0] reload = (sec64_reg == 6'h00) ? trim_reg : spr_pkg::NOMINAL_DIV;
    wire count_step = sec_tick & ctl_reg.counter_run_enable;

    // events
    wire eq_a       = count_reg == match_a_reg;
    wire eq_b       = count_reg == match_b_reg;
    wire hit_a      = eq_a & ~eq_a_reg;
    wire hit_b      = eq_b & ~eq_b_reg;
    wire pin_assert = ~wake_n_i & wake_prev_n_reg;
    wire bat_low    = ctl_reg.battery_monitor_enable & battery_low_i;

    spr_pkg::spr_event_type new_ev;
    assign new_ev.match_a          = hit_a;
    assign new_ev.match_b          = hit_b;
    assign new_ev.battery_low_flag = bat_low;
    assign new_ev.wake_pin         = pin_assert;

    // wake gating while powered off; the pin is level-sensitive, so a pin
    // already held low when power is cut wakes at once
    wire wake_pin_ok   = off_reg & ctl_reg.pin_wakeup_enable & ~wake_n_i;
    wire wake_match_ok = off_reg & ctl_reg.match_wakeup_enable & (hit_a | hit_b);
    wire wake_now      = wake_pin_ok | wake_match_ok;
    // judged on the value being written, so one write setting abort, battery enable and request is refused while battery_low_i is high
    wire abort_off     = wmerge_ctl[spr_pkg::CTL_ABORT] & wmerge_ctl[spr_pkg::CTL_BAT_EN] & battery_low_i;
    wire off_go        = wr_ctl & wmerge_ctl[spr_pkg::CTL_OFF_REQ] & ~abort_off & ~off_reg;

    spr_pkg::spr_event_type clr_ev;
    spr_pkg::spr_event_type raw_next;
    assign clr_ev   = wr_clear ? spr_pkg::spr_event_type'(wb_dat_i[spr_pkg::EV_W-1:0]) : '0;
    // a new event in the clear cycle survives the clear
    assign raw_next = (raw_reg & ~clr_ev) | new_ev;

    wire [spr_pkg::EV_W-1:0] masked = raw_reg & mask_reg;

    // read mux; unmapped reads return zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (adr)
            spr_pkg::OFF_COUNT:   rd_mux = count_reg;
            spr_pkg::OFF_MATCH_A: rd_mux = match_a_reg;
            spr_pkg::OFF_MATCH_B: rd_mux = match_b_reg;
            spr_pkg::OFF_LOAD:    rd_mux = load_reg;
            spr_pkg::OFF_CTL:     rd_mux = {24'h000000, ctl_reg};
            spr_pkg::OFF_MASK:    rd_mux = {28'h0000000, mask_reg};
            spr_pkg::OFF_RAW:     rd_mux = {28'h0000000, raw_reg};
            spr_pkg::OFF_MASKED:  rd_mux = {28'h0000000, masked};
            spr_pkg::OFF_TRIM:    rd_mux = {16'h0000, trim_reg};
            default: begin
                if (data_hit) begin
                    rd_mux = retained_words[data_ptr];
                end
            end
        endcase
    end

    // bus handshake: answer one cycle after the request, a request in the ack cycle is not taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= req;
            rdata_reg <= req ? rd_mux : rdata_reg;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_a_reg <= spr_pkg::RST_MATCH;
            match_b_reg <= spr_pkg::RST_MATCH;
            load_reg    <= spr_pkg::RST_LOAD;
            trim_reg    <= spr_pkg::RST_TRIM;
            mask_reg    <= '0;
        end else begin
            if (wr_match_a) begin
                match_a_reg <= lane_merge(match_a_reg, wb_dat_i, wb_sel_i);
            end
            if (wr_match_b) begin
                match_b_reg <= lane_merge(match_b_reg, wb_dat_i, wb_sel_i);
            end
            if (wr_load) begin
                load_reg <= lane_merge(load_reg, wb_dat_i, wb_sel_i);
            end
            if (wr_trim) begin
                trim_reg <= 16'(lane_merge({16'h0000, trim_reg}, wb_dat_i, wb_sel_i));
            end
            if (wr_mask && wb_sel_i[0]) begin
                mask_reg <= spr_pkg::spr_event_type'(wb_dat_i[spr_pkg::EV_W-1:0]);
            end
        end
    end

    // retained words; contents kept across power-off since only rst_i clears them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < WORDS; i++) begin
                retained_words[i] <= 32'h00000000;
            end
        end else if (wr_data) begin
            retained_words[data_ptr] <= lane_merge(retained_words[data_ptr], wb_dat_i, wb_sel_i);
        end
    end

    // control register; request bit mirrors the power-off state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= '0;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= spr_pkg::spr_ctl_type'(wmerge_ctl[spr_pkg::CTL_W-1:0]);
            end
            ctl_reg.power_off_request <= off_go | (off_reg & ~wake_now);
        end
    end

    // power state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            off_reg <= 1'b0;
        end else if (off_go) begin
            off_reg <= 1'b1;
        end else if (wake_now) begin
            off_reg <= 1'b0;
        end
    end

    // reference divider, predivider, seconds counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_prev_reg <= 1'b0;
            xdiv_reg      <= 7'h00;
            prediv_reg    <= spr_pkg::NOMINAL_DIV;
            sec64_reg     <= 6'h00;
            count_reg     <= spr_pkg::RST_COUNT;
        end else begin
            xtal_prev_reg <= crystal_input_i;
            if (!ctl_reg.ref_clock_enable) begin
                xdiv_reg <= 7'h00;
            end else if (xtal_rise) begin
                xdiv_reg <= xdiv_reg + 7'h01;
            end
            if (sec_tick) begin
                prediv_reg <= reload;
                sec64_reg  <= 6'(sec64_reg + 6'h01);
            end else if (ref_tick) begin
                prediv_reg <= prediv_reg - 16'h0001;
            end
            // a load write wins over a concurrent second tick
            if (wr_load) begin
                count_reg <= lane_merge(load_reg, wb_dat_i, wb_sel_i);
            end else if (count_step) begin
                count_reg <= count_reg + 32'h00000001;
            end
        end
    end

    // event capture and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_reg           <= '0;
            eq_a_reg          <= 1'b0;
            eq_b_reg          <= 1'b0;
            wake_prev_n_reg   <= 1'b1;
            irq_reg           <= 1'b0;
            regulator_off_n_o <= 1'b1;
        end else begin
            raw_reg           <= raw_next;
            eq_a_reg          <= eq_a;
            eq_b_reg          <= eq_b;
            wake_prev_n_reg   <= wake_n_i;
            irq_reg           <= |(raw_next & mask_reg);
            regulator_off_n_o <= ~((off_reg | off_go) & ~wake_now);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign irq_o    = irq_reg;

endmodule : spr_controller

`default_nettype wire

// ### verilog/spr_pkg.sv
// spr_pkg: offsets, field layout, reset values and types of the sleep/power/rtc controller.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
package spr_pkg;

    localparam logic [11:0] OFF_COUNT    = 12'h000;
    localparam logic [11:0] OFF_MATCH_A  = 12'h004;
    localparam logic [11:0] OFF_MATCH_B  = 12'h008;
    localparam logic [11:0] OFF_LOAD     = 12'h00C;
    localparam logic [11:0] OFF_CTL      = 12'h010;
    localparam logic [11:0] OFF_MASK     = 12'h014;
    localparam logic [11:0] OFF_RAW      = 12'h018;
    localparam logic [11:0] OFF_MASKED   = 12'h01C;
    localparam logic [11:0] OFF_CLEAR    = 12'h020;
    localparam logic [11:0] OFF_TRIM     = 12'h024;
    localparam logic [11:0] OFF_DATA_LO  = 12'h030;
    localparam logic [11:0] OFF_DATA_HI  = 12'h12C;

    localparam logic [31:0] RST_MATCH    = 32'hFFFFFFFF;
    localparam logic [31:0] RST_LOAD     = 32'hFFFFFFFF;
    localparam logic [31:0] RST_COUNT    = 32'h00000000;
    localparam logic [15:0] RST_TRIM     = 16'h7FFF;
    localparam logic [15:0] NOMINAL_DIV  = 16'h7FFF;

    localparam int          XTAL_DIV     = 128;
    localparam int          TRIM_PERIOD  = 64;

    // control register bit layout, bit 0 first
    localparam int          CTL_RUN      = 0;
    localparam int          CTL_OFF_REQ  = 1;
    localparam int          CTL_SRC_SEL  = 2;
    localparam int          CTL_MATCH_WE = 3;
    localparam int          CTL_PIN_WE   = 4;
    localparam int          CTL_BAT_EN   = 5;
    localparam int          CTL_CLK_EN   = 6;
    localparam int          CTL_ABORT    = 7;
    localparam int          CTL_W        = 8;

    // event bit layout, shared by raw, masked, mask and clear
    localparam int          EV_MATCH_A   = 0;
    localparam int          EV_MATCH_B   = 1;
    localparam int          EV_BAT_LOW   = 2;
    localparam int          EV_PIN       = 3;
    localparam int          EV_W         = 4;

    typedef struct packed {
        logic battery_low_abort;
        logic ref_clock_enable;
        logic battery_monitor_enable;
        logic pin_wakeup_enable;
        logic match_wakeup_enable;
        logic ref_source_select;
        logic power_off_request;
        logic counter_run_enable;
    } spr_ctl_type;

    typedef struct packed {
        logic wake_pin;
        logic battery_low_flag;
        logic match_b;
        logic match_a;
    } spr_event_type;

endpackage : spr_pkg

// ### bench/spr_assertions.sv
// spr_assert: port-level checks of the sleep/power/rtc controller.
// assumes it is bound to spr_controller and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module spr_assert #(
    parameter int ADDR_W = 12,
    parameter int WORDS  = 64
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              crystal_input_i,
    input wire logic              wake_n_i,
    input wire logic              battery_low_i,
    input wire logic              regulator_off_n_o,
    input wire logic              irq_o
);
    logic [7:0] ctl_reg;
    logic [3:0] mask_reg;
    wire taken   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctl_wr  = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == spr_pkg::OFF_CTL);
    wire mask_wr = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == spr_pkg::OFF_MASK);
    wire off_req = ctl_wr & wb_dat_i[spr_pkg::CTL_OFF_REQ] & regulator_off_n_o;
    wire blocked = wb_dat_i[spr_pkg::CTL_ABORT] & wb_dat_i[spr_pkg::CTL_BAT_EN] & battery_low_i;

    // shadow copies of control and mask, since the checker cannot see inside
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg  <= '0;
            mask_reg <= '0;
        end else begin
            if (ctl_wr) ctl_reg <= wb_dat_i[7:0];
            if (mask_wr) mask_reg <= wb_dat_i[3:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_cut_req;
        off_req && !blocked;
    endsequence
    sequence s_pin_wake;
        !regulator_off_n_o && !wake_n_i && ctl_reg[spr_pkg::CTL_PIN_WE];
    endsequence

    AST_ACK_NEXT: assert property (taken |=> wb_ack_o)
        else $error("request not acknowledged on the next edge");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_CUT_LOW: assert property (s_cut_req |=> !regulator_off_n_o)
        else $error("power-off request did not drive regulator control low");
    AST_ABORT_HOLD: assert property (off_req && blocked |=> regulator_off_n_o)
        else $error("power-off taken with low battery abort");
    AST_PIN_WAKE: assert property (s_pin_wake |=> regulator_off_n_o)
        else $error("enabled wake pin did not restore power");
    AST_NO_SOURCE: assert property (!regulator_off_n_o && !ctl_reg[spr_pkg::CTL_PIN_WE]
        && !ctl_reg[spr_pkg::CTL_MATCH_WE] && !taken |=> !regulator_off_n_o)
        else $error("woke with no wake source enabled");
    AST_IRQ_MASKED: assert property (mask_reg == 4'h0 |=> !irq_o)
        else $error("interrupt with all events masked");
    AST_CLEAR_READ: assert property (taken && !wb_we_i && wb_adr_i == spr_pkg::OFF_CLEAR
        |=> wb_dat_o == 32'h00000000)
        else $error("clear register read not zero");
    AST_RESET_OUT: assert property ($fell(rst_i) |-> regulator_off_n_o && !irq_o && !wb_ack_o)
        else $error("outputs not idle after reset");
endmodule : spr_assert

bind spr_controller spr_assert #(.ADDR_W(ADDR_W), .WORDS(WORDS)) i_spr_assert (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .crystal_input_i(crystal_input_i), .wake_n_i(wake_n_i),
    .battery_low_i(battery_low_i), .regulator_off_n_o(regulator_off_n_o), .irq_o(irq_o));
`default_nettype wire

// ### bench/spr_far_side.sv
// spr_far_side: external regulator, wake source and reference oscillator.
// assumes regulator control is active low and the wake pin idles high.
`timescale 1ns/10ps
`default_nettype none
module spr_far_side #(
    parameter int RAMP = 4
) (
    input  wire logic clk_i,
    input  wire logic regulator_off_n_i,
    input  wire logic wake_req_i,
    output logic      crystal_o,
    output logic      wake_n_o,
    output logic      supply_up_o
);
    int ramp_cnt;
    initial begin
        crystal_o   = 1'b0;
        wake_n_o    = 1'b1;
        supply_up_o = 1'b0;
        ramp_cnt    = 0;
    end
    // free-running oscillator, fastest the clock allows so a second fits the run
    always @(posedge clk_i) crystal_o <= ~crystal_o;
    // pull-up holds the pin high unless a wake is requested
    always @(posedge clk_i) wake_n_o <= ~wake_req_i;
    // supply drops at once when cut, returns only after a ramp
    always @(posedge clk_i) begin
        ramp_cnt    <= regulator_off_n_i ? ramp_cnt + 1 : 0;
        supply_up_o <= regulator_off_n_i && ramp_cnt >= RAMP;
    end
endmodule : spr_far_side
`default_nettype wire

// ### bench/test_spr_controller.sv
// test_spr_controller: register-level regression of the sleep/power/rtc controller.
// assumes spr_pkg, spr_controller, spr_far_side and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_spr_controller;
    logic             clk_i;
    logic             rst_i;
    logic             cyc;
    logic             stb;
    logic             we;
    logic             bat_low;
    logic             wake_req;
    logic [11:0]      adr;
    logic [3:0]       sel;
    logic [31:0]      wdat;
    logic [31:0]      rdat;
    wire logic [31:0] wb_dat_o;
    wire logic        ack;
    wire logic        reg_off_n;
    wire logic        irq;
    wire logic        crystal;
    wire logic        wake_n;
    wire logic        supply_up;
    int               miscompares;
    int               tests_run;
    localparam logic [11:0] OFFS [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                                          12'h014, 12'h018, 12'h01C, 12'h020, 12'h024};
    localparam logic [31:0] RSTV [10] = '{32'h00000000, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00007FFF};

    spr_controller i_spr_controller (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
        .crystal_input_i(crystal), .wake_n_i(wake_n), .battery_low_i(bat_low),
        .regulator_off_n_o(reg_off_n), .irq_o(irq));
    spr_far_side i_spr_far_side (.clk_i(clk_i), .regulator_off_n_i(reg_off_n), .wake_req_i(wake_req),
        .crystal_o(crystal), .wake_n_o(wake_n), .supply_up_o(supply_up));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n == 20) miscompares++;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        `CHK(rdat, e)
    endtask : rd_chk

    // waits for the regulator control to reach a level, bounded
    task automatic wait_reg(input logic v, input int lim);
        int n;
        n = 0;
        while (reg_off_n !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_reg

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(75000 * 20);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        rst_i    = 1'b1;
        cyc      = 1'b0;
        stb      = 1'b0;
        we       = 1'b0;
        adr      = 12'h000;
        sel      = 4'hF;
        wdat     = 32'h00000000;
        bat_low  = 1'b0;
        wake_req = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 10; i++) rd_chk(OFFS[i], RSTV[i]);
        wr(spr_pkg::OFF_DATA_LO, 32'hA5A55A5A);
        wr(spr_pkg::OFF_DATA_HI, 32'h0123CDEF);
        rd_chk(spr_pkg::OFF_DATA_LO, 32'hA5A55A5A);
        rd_chk(spr_pkg::OFF_DATA_HI, 32'h0123CDEF);
        rd_chk(12'h028, 32'h00000000);
        wr(spr_pkg::OFF_TRIM, 32'h00008001);
        rd_chk(spr_pkg::OFF_TRIM, 32'h00008001);
        bat_low <= 1'b1;
        wr(spr_pkg::OFF_CTL, 32'h000000B6);
        `CHK(reg_off_n, 1'b1)
        rd_chk(spr_pkg::OFF_RAW, 32'h00000004);
        bat_low <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr(spr_pkg::OFF_CLEAR, 32'h00000004);
        rd_chk(spr_pkg::OFF_RAW, 32'h00000000);
        wr(spr_pkg::OFF_CTL, 32'h00000056);
        `CHK(reg_off_n, 1'b0)
        wake_req <= 1'b1;
        wait_reg(1'b1, 20);
        `CHK(reg_off_n, 1'b1)
        wake_req <= 1'b0;
        rd_chk(spr_pkg::OFF_RAW, 32'h00000008);
        rd_chk(spr_pkg::OFF_DATA_HI, 32'h0123CDEF);
        `CHK(supply_up, 1'b1)
        wr(spr_pkg::OFF_CLEAR, 32'h00000008);
        // no wake source at all: only a reset can restore power
        wr(spr_pkg::OFF_CTL, 32'h00000042);
        wake_req <= 1'b1;
        repeat (20) @(posedge clk_i);
        `CHK(reg_off_n, 1'b0)
        wake_req <= 1'b0;
        rst_i    <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wr(spr_pkg::OFF_LOAD, 32'h00000100);
        rd_chk(spr_pkg::OFF_COUNT, 32'h00000100);
        wr(spr_pkg::OFF_MATCH_A, 32'h00000101);
        wr(spr_pkg::OFF_MATCH_B, 32'h00000101);
        wr(spr_pkg::OFF_CTL, 32'h0000004F);
        `CHK(reg_off_n, 1'b0)
        rd_chk(spr_pkg::OFF_COUNT, 32'h00000100);
        wait_reg(1'b1, 70000);
        `CHK(reg_off_n, 1'b1)
        rd_chk(spr_pkg::OFF_COUNT, 32'h00000101);
        rd_chk(spr_pkg::OFF_RAW, 32'h00000003);
        wr(spr_pkg::OFF_MASK, 32'h00000001);
        rd_chk(spr_pkg::OFF_MASKED, 32'h00000001);
        `CHK(irq, 1'b1)
        wr(spr_pkg::OFF_CLEAR, 32'h00000001);
        rd_chk(spr_pkg::OFF_RAW, 32'h00000002);
        `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule : test_spr_controller
`default_nettype wire
